/* logic/scpc_pkg.sv */
// constants shared by the system timebase clock configuration block
package scpc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 40000000;
    localparam int unsigned STAB_UNIT_MS = 1;
    localparam int unsigned MS_CYCLES = CLK_FREQ_HZ / 1000 * STAB_UNIT_MS;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_READBACK_CTRL = 16'h0004;
    localparam logic [15:0] ADDR_IO_UPDATE = 16'h0005;
    localparam logic [15:0] ADDR_CP_LOCK_CTRL = 16'h0100;
    localparam logic [15:0] ADDR_FB_DIV = 16'h0101;
    localparam logic [15:0] ADDR_IN_OPTIONS = 16'h0102;
    localparam logic [15:0] ADDR_NOM_PERIOD_B0 = 16'h0103;
    localparam logic [15:0] ADDR_NOM_PERIOD_B1 = 16'h0104;
    localparam logic [15:0] ADDR_NOM_PERIOD_B2 = 16'h0105;
    localparam logic [15:0] ADDR_STAB_PERIOD_B0 = 16'h0106;
    localparam logic [15:0] ADDR_STAB_PERIOD_B1 = 16'h0107;
    localparam logic [15:0] ADDR_STAB_PERIOD_B2 = 16'h0108;
    localparam int unsigned REG_COUNT = 9;
    localparam logic [15:0] REG_LAST = ADDR_STAB_PERIOD_B2;

    // entry order: index 0 is the lowest address, held in the low byte
    localparam logic [71:0] REG_MASK_VEC =
        {8'h0f, 8'hff, 8'hff, 8'h1f, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff};
    localparam logic [71:0] REG_RESET_VEC =
        {8'h00, 8'h00, 8'h01, 8'h0f, 8'h42, 8'h40, 8'h45, 8'h28, 8'h18};

    localparam int unsigned IDX_CP_LOCK_CTRL = 0;
    localparam int unsigned IDX_FB_DIV = 1;
    localparam int unsigned IDX_IN_OPTIONS = 2;
    localparam int unsigned IDX_NOM_B0 = 3;
    localparam int unsigned IDX_STAB_B0 = 6;

    localparam int unsigned UPDATE_BIT = 0;
    localparam int unsigned READBACK_BIT = 0;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned CP_EXT_FILT_BIT = 7;
    localparam int unsigned CP_MANUAL_BIT = 6;
    localparam int unsigned CP_CUR_LSB = 3;
    localparam int unsigned LOCK_TMR_DIS_BIT = 2;
    localparam int unsigned LOCK_DEPTH_LSB = 0;
    localparam int unsigned IN_PRESC_RST_BIT = 6;
    localparam int unsigned IN_PRESC_LSB = 4;
    localparam int unsigned IN_DBL_BIT = 3;
    localparam int unsigned IN_PLL_EN_BIT = 2;
    localparam int unsigned IN_SRC_LSB = 0;

    localparam int unsigned NOM_PERIOD_W = 21;
    localparam int unsigned STAB_PERIOD_W = 20;

    localparam logic [9:0] CP_STEP_UA = 10'h07d;
    localparam logic [10:0] LOCK_DEPTH_BASE = 11'h080;
    localparam logic [7:0] FB_DIV_MIN = 8'h06;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_CRYSTAL = 2'h0,
        SRC_LOW_FREQ = 2'h1,
        SRC_HIGH_FREQ = 2'h2,
        SRC_POWER_DOWN = 2'h3
    } scpc_src_t;

    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_ACQUIRE = 4'h2,
        ST_SETTLE = 4'h4,
        ST_STABLE = 4'h8
    } scpc_state_t;

endpackage

/* logic/scpc_top.sv */
// system timebase clock configuration: buffered registers and lock status
`timescale 1ns/1ps

module scpc_top
    import scpc_pkg::*;
#(
    parameter int unsigned P_MS_CYCLES = MS_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [15:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    input wire logic i_lock_detect,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_ext_loop_filter,
    output logic o_cp_manual,
    output logic [2:0] o_cp_current_code,
    output logic [9:0] o_cp_current_ua,
    output logic o_lock_timer_disable,
    output logic [10:0] o_lock_depth,
    output logic [7:0] o_fb_divider,
    output logic o_fb_div_below_min,
    output logic o_prescaler_reset,
    output logic [1:0] o_prescaler_code,
    output logic o_doubler_enable,
    output logic o_pll_enable,
    output logic [1:0] o_rx_mode,
    output logic o_rx_power_down,
    output logic [20:0] o_nominal_period_fs,
    output logic [19:0] o_stability_period_ms,
    output logic o_pll_locked,
    output logic o_clock_stable
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic [7:0] buf_reg [REG_COUNT];
    logic [7:0] act_reg [REG_COUNT];
    logic readback_buf_reg;
    logic in_block;
    logic [3:0] idx;
    logic update_pulse;

    assign in_block = (i_reg_addr >= ADDR_CP_LOCK_CTRL) && (i_reg_addr <= REG_LAST);
    assign idx = 4'(i_reg_addr - ADDR_CP_LOCK_CTRL);
    // update bit is never stored, so it reads back as zero
    assign update_pulse = i_reg_wr && (i_reg_addr == ADDR_IO_UPDATE) && i_reg_wdata[UPDATE_BIT];

    // ------------------------------------------------------------
    // buffered and active register banks
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < REG_COUNT; g++) begin : g_bank
            always_ff @(posedge i_ref_clk) begin
                if (i_reset) begin
                    buf_reg[g] <= REG_RESET_VEC[g*8 +: 8];
                end else if (i_reg_wr && in_block && (idx == 4'(g))) begin
                    buf_reg[g] <= i_reg_wdata & REG_MASK_VEC[g*8 +: 8];
                end
            end
            always_ff @(posedge i_ref_clk) begin
                if (i_reset) begin
                    act_reg[g] <= REG_RESET_VEC[g*8 +: 8];
                end else if (update_pulse) begin
                    act_reg[g] <= buf_reg[g];
                end
            end
        end
    endgenerate

    // selects which bank the readback shows; not itself buffered
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            readback_buf_reg <= 1'b0;
        end else if (i_reg_wr && (i_reg_addr == ADDR_READBACK_CTRL)) begin
            readback_buf_reg <= i_reg_wdata[READBACK_BIT];
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] rd_next;

    // unmapped and unused bits read zero
    always_comb begin
        rd_next = 8'h00;
        if (in_block) begin
            rd_next = readback_buf_reg ? buf_reg[idx] : act_reg[idx];
        end else if (i_reg_addr == ADDR_READBACK_CTRL) begin
            rd_next = {7'h00, readback_buf_reg};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rd_next;
            end
        end
    end

    // ------------------------------------------------------------
    // decoded control outputs, all from active registers
    // ------------------------------------------------------------
    logic [7:0] cp_ctrl;
    logic [7:0] in_opt;

    assign cp_ctrl = act_reg[IDX_CP_LOCK_CTRL];
    assign in_opt = act_reg[IDX_IN_OPTIONS];

    assign o_ext_loop_filter = cp_ctrl[CP_EXT_FILT_BIT];
    assign o_cp_manual = cp_ctrl[CP_MANUAL_BIT];
    assign o_cp_current_code = cp_ctrl[CP_CUR_LSB +: 3];
    assign o_cp_current_ua = 10'(({7'h00, o_cp_current_code} + 10'h001) * CP_STEP_UA);
    assign o_lock_timer_disable = cp_ctrl[LOCK_TMR_DIS_BIT];
    assign o_lock_depth = LOCK_DEPTH_BASE << cp_ctrl[LOCK_DEPTH_LSB +: 2];
    // divider value, flag for illegal low setting
    assign o_fb_divider = act_reg[IDX_FB_DIV];
    assign o_fb_div_below_min = (act_reg[IDX_FB_DIV] < FB_DIV_MIN);
    assign o_prescaler_reset = in_opt[IN_PRESC_RST_BIT];
    assign o_prescaler_code = in_opt[IN_PRESC_LSB +: 2];
    assign o_doubler_enable = in_opt[IN_DBL_BIT];
    assign o_pll_enable = in_opt[IN_PLL_EN_BIT];
    assign o_rx_mode = in_opt[IN_SRC_LSB +: 2];
    assign o_rx_power_down = (in_opt[IN_SRC_LSB +: 2] == SRC_POWER_DOWN);
    assign o_nominal_period_fs = NOM_PERIOD_W'({act_reg[IDX_NOM_B0 + 2],
                                                act_reg[IDX_NOM_B0 + 1],
                                                act_reg[IDX_NOM_B0]});
    assign o_stability_period_ms = STAB_PERIOD_W'({act_reg[IDX_STAB_B0 + 2],
                                                   act_reg[IDX_STAB_B0 + 1],
                                                   act_reg[IDX_STAB_B0]});

    // ------------------------------------------------------------
    // lock and stability tracking
    // ------------------------------------------------------------
    scpc_state_t state_reg;
    scpc_state_t state_next;
    logic [10:0] lock_cnt_reg;
    logic [15:0] ms_cnt_reg;
    logic [19:0] stab_cnt_reg;
    logic ms_tick;
    logic depth_met;
    logic stab_met;

    assign ms_tick = (ms_cnt_reg == 16'(P_MS_CYCLES - 1));
    // a disabled timer lets the detector declare lock at once
    assign depth_met = o_lock_timer_disable || (lock_cnt_reg == (o_lock_depth - 11'h001));
    assign stab_met = (stab_cnt_reg >= o_stability_period_ms);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (o_pll_enable) begin
                    state_next = ST_ACQUIRE;
                end
            end
            ST_ACQUIRE: begin
                if (!o_pll_enable) begin
                    state_next = ST_OFF;
                end else if (i_lock_detect && depth_met) begin
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (!o_pll_enable) begin
                    state_next = ST_OFF;
                end else if (!i_lock_detect) begin
                    state_next = ST_ACQUIRE;
                end else if (stab_met) begin
                    state_next = ST_STABLE;
                end
            end
            ST_STABLE: begin
                if (!o_pll_enable) begin
                    state_next = ST_OFF;
                end else if (!i_lock_detect) begin
                    state_next = ST_ACQUIRE;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            lock_cnt_reg <= 11'h000;
        end else if ((state_reg != ST_ACQUIRE) || !i_lock_detect || depth_met) begin
            lock_cnt_reg <= 11'h000;
        end else begin
            lock_cnt_reg <= lock_cnt_reg + 11'h001;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            ms_cnt_reg <= 16'h0000;
            stab_cnt_reg <= 20'h0_0000;
        end else if (state_reg != ST_SETTLE) begin
            ms_cnt_reg <= 16'h0000;
            stab_cnt_reg <= 20'h0_0000;
        end else if (ms_tick) begin
            ms_cnt_reg <= 16'h0000;
            // saturate so a long period never wraps to an early stable
            if (stab_cnt_reg != 20'hf_ffff) begin
                stab_cnt_reg <= stab_cnt_reg + 20'h0_0001;
            end
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 16'h0001;
        end
    end

    assign o_pll_locked = (state_reg == ST_SETTLE) || (state_reg == ST_STABLE);
    assign o_clock_stable = (state_reg == ST_STABLE);

endmodule

/* bench/scpc_chk.sv */
// assertions on the timebase clock configuration ports
`timescale 1ns/1ps
module scpc_chk (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [15:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    input wire logic i_lock_detect,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic [2:0] o_cp_current_code,
    input wire logic [9:0] o_cp_current_ua,
    input wire logic o_lock_timer_disable,
    input wire logic [10:0] o_lock_depth,
    input wire logic [7:0] o_fb_divider,
    input wire logic o_fb_div_below_min,
    input wire logic o_pll_enable,
    input wire logic [1:0] o_rx_mode,
    input wire logic o_rx_power_down,
    input wire logic [20:0] o_nominal_period_fs,
    input wire logic o_pll_locked,
    input wire logic o_clock_stable
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    logic upd;
    assign upd = i_reg_wr && (i_reg_addr == 16'h0005) && i_reg_wdata[0];
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    AST_RVALID: assert property (!$past(i_reset) |-> o_reg_rvalid == $past(i_reg_rd))
        else $error("read valid not one cycle after read");
    AST_RDATA_HOLD: assert property (!$past(i_reset) && !$past(i_reg_rd) |-> $stable(o_reg_rdata))
        else $error("read data moved without a read");
    // outputs follow the update write by one cycle
    AST_ACTIVE_HOLD: assert property (!$past(i_reset) && !$past(upd) && !$past(upd, 2)
        |-> $stable({o_fb_divider, o_nominal_period_fs, o_cp_current_code, o_rx_mode}))
        else $error("active value changed without update");
    AST_CP_UA: assert property (o_cp_current_ua == (10'(o_cp_current_code) + 10'h001) * 10'h07d)
        else $error("charge pump current wrong for code");
    AST_DEPTH: assert property (o_lock_depth inside {11'h080, 11'h100, 11'h200, 11'h400})
        else $error("lock depth not a legal value");
    AST_RX_OFF: assert property (o_rx_power_down == (o_rx_mode == 2'h3))
        else $error("receiver power down mismatch");
    AST_BELOW_MIN: assert property (o_fb_div_below_min == (o_fb_divider < 8'h06))
        else $error("divider range flag wrong");
    AST_LOCK_TMR: assert property ($rose(o_pll_locked) && !o_lock_timer_disable
        |-> $past(i_lock_detect) && $past(i_lock_detect, 64) && $past(i_lock_detect, 128))
        else $error("lock declared before timer depth");
    AST_STABLE_LOCK: assert property (o_clock_stable |-> o_pll_locked)
        else $error("stable without lock");
    AST_LOSS: assert property (o_pll_locked && !i_lock_detect |=> !o_pll_locked)
        else $error("lock held after detector loss");
    AST_PLL_OFF: assert property (!o_pll_enable [*2] |-> !o_pll_locked)
        else $error("locked while pll disabled");
    COV_LOCK: cover property ($rose(o_pll_locked));
    COV_STABLE: cover property ($rose(o_clock_stable));
    COV_UPD: cover property (upd);
    COV_RX_OFF: cover property ($rose(o_rx_power_down));
endmodule

/* bench/scpc_lock_src.sv */
// lock detector stand-in for the timebase source
`timescale 1ns/1ps
module scpc_lock_src #(
    parameter int unsigned P_FAST = 4,
    parameter int unsigned P_SLOW = 40
) (
    input wire logic i_ref_clk,
    input wire logic i_pll_enable,
    input wire logic i_slow,
    input wire logic i_drop,
    output logic o_lock_detect
);
    int unsigned cnt = 0;
    initial o_lock_detect = 1'b0;
    always @(posedge i_ref_clk) begin
        if (!i_pll_enable || i_drop) begin
            cnt <= 0;
            o_lock_detect <= 1'b0;
        end else if (cnt >= (i_slow ? P_SLOW : P_FAST)) begin
            o_lock_detect <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

/* bench/scpc_tb.sv */
// self-checking bench for the timebase clock configuration block
`timescale 1ns/1ps
module testbench;
    import scpc_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [15:0] i_reg_addr = 16'h0000;
    logic i_reg_wr = 1'b0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_rd = 1'b0;
    logic i_lock_detect;
    logic slow = 1'b0;
    logic drop = 1'b0;
    logic [7:0] o_reg_rdata, o_fb_divider;
    logic [2:0] o_cp_current_code;
    logic [9:0] o_cp_current_ua;
    logic [10:0] o_lock_depth;
    logic [1:0] o_prescaler_code, o_rx_mode;
    logic [20:0] o_nominal_period_fs;
    logic [19:0] o_stability_period_ms;
    logic o_reg_rvalid, o_ext_loop_filter, o_cp_manual, o_lock_timer_disable, o_fb_div_below_min;
    logic o_prescaler_reset, o_doubler_enable, o_pll_enable, o_rx_power_down;
    logic o_pll_locked, o_clock_stable;
    int err_total = 0;
    int checks = 0;
    int n;
    int h;
    localparam logic [71:0] RST = {8'h00, 8'h00, 8'h01, 8'h0f, 8'h42, 8'h40, 8'h45, 8'h28, 8'h18};
    localparam logic [71:0] MSK = {8'h0f, 8'hff, 8'hff, 8'h1f, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff};

    always #12.5 i_ref_clk = ~i_ref_clk;

    // short millisecond keeps the stability wait brief
    scpc_top #(.P_MS_CYCLES(10)) u_scpc_top (.*);
    scpc_lock_src u_scpc_lock_src (.i_ref_clk(i_ref_clk), .i_pll_enable(o_pll_enable),
        .i_slow(slow), .i_drop(drop), .o_lock_detect(i_lock_detect));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge i_ref_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_ref_clk);
        i_reg_rd <= 1'b0;
        #1;
        chk("rvalid", 32'h1, {31'h0, o_reg_rvalid});
        chk("rdata", {24'h0, e}, {24'h0, o_reg_rdata});
    endtask
    task automatic upd();
        wr(ADDR_IO_UPDATE, 8'h01);
        @(posedge i_ref_clk);
        #1;
    endtask
    task automatic wait_on(input int sel, input int lim, output int cnt, output int hi);
        cnt = 0;
        hi = 0;
        while ((sel == 0 ? o_pll_locked : o_clock_stable) !== 1'b1) begin
            @(posedge i_ref_clk);
            #1;
            cnt++;
            hi += (i_lock_detect === 1'b1);
            if (cnt > lim) begin
                err_total++;
                $display("BAD wait %0d expected 1 seen 0", sel);
                tally_and_finish();
            end
        end
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd(ADDR_CP_LOCK_CTRL + 16'(i), RST[i*8 +: 8]);
        end
        chk("nominal", 32'h000f_4240, {11'h0, o_nominal_period_fs});
        chk("stability", 32'h1, {12'h0, o_stability_period_ms});
        chk("cp_ua", 32'h1f4, {22'h0, o_cp_current_ua});
        chk("depth", 32'h80, {21'h0, o_lock_depth});
        chk("cfg", 32'h45, {22'h0, o_ext_loop_filter, o_cp_manual, o_lock_timer_disable, o_prescaler_reset, o_prescaler_code, o_doubler_enable, o_pll_enable, o_rx_mode});
        wr(ADDR_FB_DIV, 8'h30);
        chk("fb buffered", 32'h28, {24'h0, o_fb_divider});
        rd(ADDR_FB_DIV, 8'h28);
        wr(ADDR_READBACK_CTRL, 8'h01);
        rd(ADDR_FB_DIV, 8'h30);
        wr(ADDR_READBACK_CTRL, 8'h00);
        upd();
        chk("fb active", 32'h30, {24'h0, o_fb_divider});
        rd(ADDR_IO_UPDATE, 8'h00);
        for (int i = 0; i < 9; i++) begin
            wr(ADDR_CP_LOCK_CTRL + 16'(i), 8'hff);
        end
        wr(16'h0109, 8'hff);
        upd();
        for (int i = 0; i < 9; i++) begin
            rd(ADDR_CP_LOCK_CTRL + 16'(i), MSK[i*8 +: 8]);
        end
        rd(16'h0109, 8'h00);
        chk("nominal max", 32'h001f_ffff, {11'h0, o_nominal_period_fs});
        chk("stab max", 32'h000f_ffff, {12'h0, o_stability_period_ms});
        chk("cfg max", 32'h3ff, {22'h0, o_ext_loop_filter, o_cp_manual, o_lock_timer_disable, o_prescaler_reset, o_prescaler_code, o_doubler_enable, o_pll_enable, o_rx_mode});
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CP_LOCK_CTRL, {2'b01, 3'(c), 1'b0, 2'(c)});
            wr(ADDR_IN_OPTIONS, {2'b00, 2'(c), 2'b01, 2'(c)});
            wr(ADDR_FB_DIV, 8'(c + 2));
            upd();
            chk("cp code", 32'(c), {29'h0, o_cp_current_code});
            chk("cp_ua", 32'((c + 1) * 125), {22'h0, o_cp_current_ua});
            chk("depth", 32'(128 << (c % 4)), {21'h0, o_lock_depth});
            chk("presc rx", 32'((c % 4) * 5), {28'h0, o_prescaler_code, o_rx_mode});
            chk("rx off", 32'(c % 4 == 3), {31'h0, o_rx_power_down});
            chk("below min", 32'(c + 2 < 6), {31'h0, o_fb_div_below_min});
        end
        // second reset mid-run, slow detector start
        @(posedge i_ref_clk);
        i_reset <= 1'b1;
        drop <= 1'b1;
        slow <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        drop <= 1'b0;
        wait_on(0, 400, n, h);
        chk("lock depth", 32'h1, 32'(h >= 127 && h <= 130));
        wait_on(1, 100, n, h);
        chk("stable time", 32'h1, 32'(n >= 9 && n <= 12));
        @(posedge i_ref_clk);
        drop <= 1'b1;
        slow <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        #1;
        chk("lost lock", 32'h0, {30'h0, o_pll_locked, o_clock_stable});
        drop <= 1'b0;
        wr(ADDR_CP_LOCK_CTRL, 8'h1c);
        upd();
        wait_on(0, 20, n, h);
        chk("no timer lock", 32'h1, 32'(n <= 8));
        // deeper timer: lock only after 256 detector cycles
        @(posedge i_ref_clk);
        drop <= 1'b1;
        wr(ADDR_CP_LOCK_CTRL, 8'h19);
        upd();
        @(posedge i_ref_clk);
        drop <= 1'b0;
        wait_on(0, 400, n, h);
        chk("lock depth 256", 32'h1, 32'(h >= 255 && h <= 258));
        wr(ADDR_IN_OPTIONS, 8'h41);
        upd();
        repeat (2) @(posedge i_ref_clk);
        #1;
        chk("pll off", 32'h0, {30'h0, o_pll_enable, o_pll_locked});
        tally_and_finish();
    end
endmodule

bind scpc_top scpc_chk u_scpc_chk (.*);
